// file: include/route_pkg.sv
// constants shared by the audio output routing matrix
package route_pkg;
    // register byte offsets (word aligned)
    localparam logic [7:0] OFS_PRIMARY = 8'h00;
    localparam logic [7:0] OFS_SECOND = 8'h20;
    localparam logic [7:0] OFS_OPTICAL = 8'h40;
    localparam logic [7:0] OFS_FORMAT = 8'h60;
    localparam logic [7:0] OFS_ANALOG_LEVEL = 8'h64;
    localparam logic [7:0] OFS_DIGITAL_LEVEL = 8'h68;
    localparam logic [7:0] OFS_STATUS = 8'h6C;
    // source selector encoding
    localparam logic [5:0] SRC_SILENCE = 6'h00;
    localparam logic [5:0] SRC_DSP_A = 6'h01;
    localparam logic [5:0] SRC_DSP_B = 6'h09;
    localparam logic [5:0] SRC_ANALOG = 6'h11;
    localparam logic [5:0] SRC_DIGITAL = 6'h13;
    localparam logic [5:0] SRC_OPTICAL = 6'h1B;
    localparam logic [5:0] SRC_LAST = 6'h22;
    localparam int SRC_COUNT = 35;
    // optical selector: 0..7 main output, 8..15 optical input passthrough
    localparam logic [3:0] OPT_PASS = 4'h8;
    // format values for output pair 1/2
    localparam logic FMT_CONSUMER = 1'b0;
    localparam logic FMT_PROFESSIONAL = 1'b1;
    // level: gain in 1/128 steps, unity is full
    localparam logic [7:0] LEVEL_UNITY = 8'h80;
    localparam int LEVEL_SHIFT = 7;
    // reset values
    localparam logic [5:0] RST_SECOND = 6'h00;
    localparam logic RST_FORMAT = 1'b1;
endpackage : route_pkg

// file: core/sat_add.sv
// saturating two-input sample adder for one main output
`timescale 1ns/1ps
`default_nettype none
module sat_add #(
    parameter int W = 24
) (
    input wire logic signed [W-1:0] a,
    input wire logic signed [W-1:0] b,
    output logic signed [W-1:0] y
);
    // full precision sum, one guard bit
    logic signed [W:0] sum;
    localparam logic signed [W-1:0] POS_MAX = {1'b0, {(W-1){1'b1}}};
    localparam logic signed [W-1:0] NEG_MAX = {1'b1, {(W-1){1'b0}}};

    assign sum = {a[W-1], a} + {b[W-1], b};

    always_comb begin
        if (sum[W] != sum[W-1]) begin
            // overflow: sign of the true sum picks the rail
            y = sum[W] ? NEG_MAX : POS_MAX;
        end else begin
            y = sum[W-1:0];
        end
    end
endmodule : sat_add
`default_nettype wire

// file: core/audio_output_routing_matrix.sv
// audio output routing matrix with avalon-mm configuration
//
// Operation
// - eight main outputs, each with own primary
// - sources: dsp A/B, analog, digital, optical
// - silence source drives zero samples
// - analog outputs carry main outputs 7/8
// - consumer pair carries main outputs 1/2
// - format setting picks consumer or professional framing
// - pair 1/2 and consumer share signal, framing
// - each optical output selects a main output
// - optical selector may pass optical input
// - each main output adds an optional second
// - separate analog and digital output levels
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module audio_output_routing_matrix #(
    parameter int W = 24
) (
    input wire logic ref_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // frame clock from the sample link, asynchronous
    input wire logic frame_clk,
    // sources
    input wire logic [7:0][W-1:0] dsp_a_sample,
    input wire logic [7:0][W-1:0] dsp_b_sample,
    input wire logic [1:0][W-1:0] analog_in_sample,
    input wire logic [7:0][W-1:0] digital_in_sample,
    input wire logic [7:0][W-1:0] optical_in_sample,
    // physical outputs
    output logic [7:0][W-1:0] main_output,
    output logic [1:0][W-1:0] analog_output,
    output logic [1:0][W-1:0] consumer_output,
    output logic [7:0][W-1:0] optical_output,
    output logic pair12_professional,
    output logic sample_valid
);
    // elaboration check: adder and level stage serve 8 to 32 bit samples
    if (W < 8 || W > 32) begin : g_bad_width
        $error("sample width out of range");
    end
    // software shadow and frame-committed active settings
    logic [5:0] sh_prim [8];
    logic [5:0] sh_sec [8];
    logic [3:0] sh_opt [8];
    logic sh_fmt;
    logic [7:0] sh_alvl;
    logic [7:0] sh_dlvl;
    logic [5:0] act_prim [8];
    logic [5:0] act_sec [8];
    logic [3:0] act_opt [8];
    logic act_fmt;
    logic [7:0] act_alvl;
    logic [7:0] act_dlvl;
    // frame clock synchroniser and edge pipeline
    logic fclk_meta;
    logic fclk_sync;
    logic fclk_prev;
    logic frame_tick;
    logic tick_d;
    logic [15:0] frame_count;
    // flat source table and mix results
    logic signed [W-1:0] all_src [route_pkg::SRC_COUNT];
    logic signed [W-1:0] prim_s [8];
    logic signed [W-1:0] sec_s [8];
    logic signed [W-1:0] mix_s [8];
    logic signed [W-1:0] main_mix [8];
    logic [5:0] widx;
    // selector is a defined source code
    function automatic logic src_ok(input logic [5:0] sel);
        src_ok = (sel <= route_pkg::SRC_LAST);
    endfunction : src_ok
    // gain scaling, gain clamped to unity at write so no overflow
    function automatic logic [W-1:0] apply_level(input logic [W-1:0] s, input logic [7:0] g);
        logic signed [W+8:0] p;
        p = $signed(s) * $signed({1'b0, g});
        apply_level = W'(p >>> route_pkg::LEVEL_SHIFT);
    endfunction : apply_level
    // clamp level writes to unity
    function automatic logic [7:0] lvl_clamp(input logic [31:0] d);
        lvl_clamp = (d[7:0] > route_pkg::LEVEL_UNITY) ? route_pkg::LEVEL_UNITY : d[7:0];
    endfunction : lvl_clamp
    assign widx = address[7:2]; // word index within a register bank
    // bus handshake: one wait cycle, then a single acknowledge cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else if (read || write) begin
            waitrequest <= 1'b0;
        end
    end

    // read data captured in the wait cycle, valid at the acknowledge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= 32'h0000_0000;
            if (address < route_pkg::OFS_SECOND) begin
                readdata[5:0] <= sh_prim[widx[2:0]];
            end else if (address < route_pkg::OFS_OPTICAL) begin
                readdata[5:0] <= sh_sec[widx[2:0]];
            end else if (address < route_pkg::OFS_FORMAT) begin
                readdata[3:0] <= sh_opt[widx[2:0]];
            end else if (address == route_pkg::OFS_FORMAT) begin
                readdata[0] <= sh_fmt;
            end else if (address == route_pkg::OFS_ANALOG_LEVEL) begin
                readdata[7:0] <= sh_alvl;
            end else if (address == route_pkg::OFS_DIGITAL_LEVEL) begin
                readdata[7:0] <= sh_dlvl;
            end else if (address == route_pkg::OFS_STATUS) begin
                // status: frame counter plus active format
                readdata <= {15'h0000, act_fmt, frame_count};
            end
        end
    end

    // register writes into the shadow set; unmapped writes are dropped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                sh_prim[i] <= route_pkg::SRC_DSP_A + 6'(i);
                sh_sec[i] <= route_pkg::RST_SECOND;
                sh_opt[i] <= 4'(i);
            end
            sh_fmt <= route_pkg::RST_FORMAT;
            sh_alvl <= route_pkg::LEVEL_UNITY;
            sh_dlvl <= route_pkg::LEVEL_UNITY;
        end else if (write && !waitrequest) begin
            if (address < route_pkg::OFS_SECOND) begin
                sh_prim[widx[2:0]] <= writedata[5:0];
            end else if (address < route_pkg::OFS_OPTICAL) begin
                sh_sec[widx[2:0]] <= writedata[5:0];
            end else if (address < route_pkg::OFS_FORMAT) begin
                sh_opt[widx[2:0]] <= writedata[3:0];
            end else if (address == route_pkg::OFS_FORMAT) begin
                sh_fmt <= writedata[0];
            end else if (address == route_pkg::OFS_ANALOG_LEVEL) begin
                sh_alvl <= lvl_clamp(writedata);
            end else if (address == route_pkg::OFS_DIGITAL_LEVEL) begin
                sh_dlvl <= lvl_clamp(writedata);
            end
        end
    end
    // two-flop synchroniser and rising edge of the frame clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fclk_meta <= 1'b0;
            fclk_sync <= 1'b0;
            fclk_prev <= 1'b0;
            frame_tick <= 1'b0;
            tick_d <= 1'b0;
            frame_count <= 16'h0000;
        end else begin
            fclk_meta <= frame_clk;
            fclk_sync <= fclk_meta;
            fclk_prev <= fclk_sync;
            frame_tick <= fclk_sync && !fclk_prev;
            tick_d <= frame_tick;
            if (frame_tick) begin
                frame_count <= frame_count + 16'h0001;
            end
        end
    end
    // commit settings only at a frame edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                act_prim[i] <= route_pkg::SRC_DSP_A + 6'(i);
                act_sec[i] <= route_pkg::RST_SECOND;
                act_opt[i] <= 4'(i);
            end
            act_fmt <= route_pkg::RST_FORMAT;
            act_alvl <= route_pkg::LEVEL_UNITY;
            act_dlvl <= route_pkg::LEVEL_UNITY;
        end else if (frame_tick) begin
            act_prim <= sh_prim;
            act_sec <= sh_sec;
            act_opt <= sh_opt;
            act_fmt <= sh_fmt;
            act_alvl <= sh_alvl;
            act_dlvl <= sh_dlvl;
        end
    end

    assign all_src[0] = '0;
    // flat table of every selectable source
    for (genvar k = 0; k < 8; k++) begin : g_src
        assign all_src[route_pkg::SRC_DSP_A + k] = dsp_a_sample[k];
        assign all_src[route_pkg::SRC_DSP_B + k] = dsp_b_sample[k];
        assign all_src[route_pkg::SRC_DIGITAL + k] = digital_in_sample[k];
        assign all_src[route_pkg::SRC_OPTICAL + k] = optical_in_sample[k];
    end
    for (genvar k = 0; k < 2; k++) begin : g_ana
        assign all_src[route_pkg::SRC_ANALOG + k] = analog_in_sample[k];
    end
    // per-channel independent primary and second pick
    for (genvar c = 0; c < 8; c++) begin : g_ch
        // undefined codes behave as silence
        assign prim_s[c] = src_ok(act_prim[c]) ? all_src[act_prim[c]] : '0;
        assign sec_s[c] = src_ok(act_sec[c]) ? all_src[act_sec[c]] : '0;
        sat_add #(.W(W)) u_sum (
            .a(prim_s[c]),
            .b(sec_s[c]),
            .y(mix_s[c])
        );
        // two positive sources never wrap to a negative sum
        a_clamp_high: assert property (@(posedge ref_clk) disable iff (rst)
            prim_s[c] > 0 && sec_s[c] > 0 |-> mix_s[c] > 0) else $error("summed sample wrapped");
    end
    // capture the frame's mix one cycle after the commit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) main_mix[i] <= '0;
        end else if (tick_d) begin
            main_mix <= mix_s;
        end
    end
    // levels applied at the output stage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            main_output <= '0;
            analog_output <= '0;
            consumer_output <= '0;
            optical_output <= '0;
            pair12_professional <= route_pkg::RST_FORMAT;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= tick_d;
            if (tick_d) begin
                for (int i = 0; i < 8; i++) begin
                    main_output[i] <= apply_level(mix_s[i], act_dlvl);
                    // optical mirrors a chosen main output
                    // or passes an optical input straight through
                    if (act_opt[i] >= route_pkg::OPT_PASS) begin
                        optical_output[i] <= apply_level(optical_in_sample[act_opt[i][2:0]], act_dlvl);
                    end else begin
                        optical_output[i] <= apply_level(mix_s[act_opt[i][2:0]], act_dlvl);
                    end
                end
                // analog taps main outputs 7 and 8
                analog_output[0] <= apply_level(mix_s[6], act_alvl);
                analog_output[1] <= apply_level(mix_s[7], act_alvl);
                // consumer pair taps main outputs 1 and 2
                consumer_output[0] <= apply_level(mix_s[0], act_dlvl);
                consumer_output[1] <= apply_level(mix_s[1], act_dlvl);
                // one framing select for both ports
                pair12_professional <= act_fmt;
            end
        end
    end
    // checks on the running design
    sequence s_commit;
        frame_tick ##1 tick_d;
    endsequence
    a_frame_commit: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(act_fmt) |-> $past(frame_tick)) else $error("setting changed mid-frame");
    a_pipe_valid: assert property (@(posedge ref_clk) disable iff (rst)
        s_commit |=> sample_valid) else $error("frame output not produced");
    a_silence_zero: assert property (@(posedge ref_clk) disable iff (rst)
        tick_d && act_prim[0] == route_pkg::SRC_SILENCE && act_sec[0] == route_pkg::SRC_SILENCE
        |=> main_mix[0] == '0) else $error("silence not zero");
    a_source_pick: assert property (@(posedge ref_clk) disable iff (rst)
        tick_d && act_prim[1] == route_pkg::SRC_DSP_B && act_sec[1] == route_pkg::SRC_SILENCE
        |=> main_mix[1] == $past(dsp_b_sample[0])) else $error("wrong source");
    a_analog_tap: assert property (@(posedge ref_clk) disable iff (rst)
        sample_valid && act_alvl == act_dlvl |-> analog_output[1] == main_output[7])
        else $error("analog tap mismatch");
    a_consumer_tap: assert property (@(posedge ref_clk) disable iff (rst)
        sample_valid |-> consumer_output == main_output[1:0]) else $error("consumer tap mismatch");
    a_format_same: assert property (@(posedge ref_clk) disable iff (rst)
        sample_valid |-> pair12_professional == act_fmt) else $error("framing mismatch");
    a_optical_mirror: assert property (@(posedge ref_clk) disable iff (rst)
        sample_valid && act_opt[0] < route_pkg::OPT_PASS
        |-> optical_output[0] == main_output[act_opt[0][2:0]]) else $error("optical mirror wrong");
    a_unity_level: assert property (@(posedge ref_clk) disable iff (rst)
        sample_valid && act_dlvl == route_pkg::LEVEL_UNITY |-> main_output[2] == main_mix[2])
        else $error("unity level altered sample");
    a_wait_single: assert property (@(posedge ref_clk) disable iff (rst)
        !waitrequest |=> waitrequest) else $error("ack longer than one cycle");
endmodule : audio_output_routing_matrix
`default_nettype wire

// file: tb/output_port_model.sv
// partner model: frame clock of the sample link and the output port sink
`timescale 1ns/1ps
`default_nettype none
module output_port_model #(
    parameter real HALF_NS = 40.0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_valid,
    output logic frame_clk,
    output int frames_seen
);
    // free running frame clock, phase unrelated to ref_clk
    initial begin
        frame_clk = 1'b0;
        #7.3;
        forever #(HALF_NS) frame_clk = ~frame_clk;
    end
    // port side counts the frames it was handed
    always @(posedge ref_clk or posedge rst) begin
        if (rst) frames_seen <= 0;
        else if (sample_valid === 1'b1) frames_seen <= frames_seen + 1;
    end
endmodule : output_port_model
`default_nettype wire

// file: tb/tb_audio_output_routing_matrix.sv
// self-checking bench for the audio output routing matrix
`timescale 1ns/1ps
`default_nettype none
module tb_audio_output_routing_matrix;
    localparam int W = 24;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic frame_clk;
    logic [7:0][W-1:0] dsp_a = '0;
    logic [7:0][W-1:0] dsp_b = '0;
    logic [1:0][W-1:0] analog_in = '0;
    logic [7:0][W-1:0] digital_in = '0;
    logic [7:0][W-1:0] optical_in = '0;
    logic [7:0][W-1:0] main_output;
    logic [1:0][W-1:0] analog_output;
    logic [1:0][W-1:0] consumer_output;
    logic [7:0][W-1:0] optical_output;
    logic pair12_professional;
    logic sample_valid;
    int frames_seen;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    // expected configuration, kept by the bench
    int prim [8];
    int sec [8];
    int opt [8];
    int alev;
    int dlev;
    logic fmt;
    logic [31:0] q;
    logic [W-1:0] held;

    always #2 ref_clk = ~ref_clk;

    audio_output_routing_matrix #(.W(W)) DUT (.ref_clk(ref_clk), .rst(rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .frame_clk(frame_clk),
        .dsp_a_sample(dsp_a), .dsp_b_sample(dsp_b), .analog_in_sample(analog_in),
        .digital_in_sample(digital_in), .optical_in_sample(optical_in),
        .main_output(main_output), .analog_output(analog_output),
        .consumer_output(consumer_output), .optical_output(optical_output),
        .pair12_professional(pair12_professional), .sample_valid(sample_valid));

    output_port_model ports (.ref_clk(ref_clk), .rst(rst), .sample_valid(sample_valid),
        .frame_clk(frame_clk), .frames_seen(frames_seen));

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d failures %0d frames %0d", check_count, failures, frames_seen);
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            finish_test();
        end
    end

    // compare one value
    task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        // only the bench timeout ends a wait that never sees the acknowledge
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input int d);
        logic [31:0] r;
        bus(1'b1, a, 32'(d), r);
    endtask : wr

    // wait for delivered frames
    task automatic frames(input int k);
        for (int i = 0; i < k; i++) begin
            do @(posedge ref_clk); while (sample_valid !== 1'b1);
        end
    endtask : frames

    // fresh random samples on all sources, keep masks low bits
    task automatic rand_src(input logic [W-1:0] keep);
        for (int n = 0; n < 8; n++) begin
            dsp_a[n] <= W'($urandom()) & keep;
            dsp_b[n] <= W'($urandom()) & keep;
            digital_in[n] <= W'($urandom()) & keep;
            optical_in[n] <= W'($urandom()) & keep;
        end
        analog_in[0] <= W'($urandom()) & keep;
        analog_in[1] <= W'($urandom()) & keep;
    endtask : rand_src

    // value of a source code, silence for 0 and codes past the last
    function automatic longint val(input int c);
        if (c >= 1 && c <= 8) return $signed(dsp_a[c-1]);
        if (c >= 9 && c <= 16) return $signed(dsp_b[c-9]);
        if (c == 17 || c == 18) return $signed(analog_in[c-17]);
        if (c >= 19 && c <= 26) return $signed(digital_in[c-19]);
        if (c >= 27 && c <= 34) return $signed(optical_in[c-27]);
        return 0;
    endfunction : val

    // clamp to full scale
    function automatic longint sat(input longint s);
        longint hi;
        hi = (longint'(1) <<< (W - 1)) - 1;
        if (s > hi) return hi;
        if (s < -hi - 1) return -hi - 1;
        return s;
    endfunction : sat

    function automatic logic [W-1:0] lvl(input longint s, input int l);
        return W'((s * l) / 128);
    endfunction : lvl

    // write the whole expected configuration
    task automatic load_cfg();
        for (int n = 0; n < 8; n++) begin
            wr(route_pkg::OFS_PRIMARY + 8'(4 * n), prim[n]);
            wr(route_pkg::OFS_SECOND + 8'(4 * n), sec[n]);
            wr(route_pkg::OFS_OPTICAL + 8'(4 * n), opt[n]);
        end
        wr(route_pkg::OFS_FORMAT, int'(fmt));
        wr(route_pkg::OFS_ANALOG_LEVEL, alev);
        wr(route_pkg::OFS_DIGITAL_LEVEL, dlev);
    endtask : load_cfg

    // compare every output port with the expected routing
    task automatic check_all();
        longint raw [8];
        longint e;
        for (int n = 0; n < 8; n++) raw[n] = sat(val(prim[n]) + val(sec[n]));
        for (int n = 0; n < 8; n++) begin
            check(main_output[n], lvl(raw[n], dlev));
            e = opt[n] < 8 ? raw[opt[n]] : longint'($signed(optical_in[opt[n] - 8]));
            check(optical_output[n], lvl(e, dlev));
        end
        for (int k = 0; k < 2; k++) begin
            check(analog_output[k], lvl(raw[6 + k], alev));
            check(consumer_output[k], lvl(raw[k], dlev));
        end
        check(pair12_professional, fmt);
    endtask : check_all

    initial begin
        void'($urandom(10282));
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // reset routing: dsp A straight through, optical mirrors main
        for (int n = 0; n < 8; n++) begin
            prim[n] = 1 + n;
            sec[n] = 0;
            opt[n] = n;
        end
        alev = 128;
        dlev = 128;
        fmt = 1'b1;
        rand_src('1);
        frames(3);
        check_all();
        bus(1'b0, route_pkg::OFS_PRIMARY + 8'h04, 32'h0, q);
        check(q[W-1:0], 24'h000002);
        bus(1'b0, 8'h70, 32'h0, q);
        check(q[W-1:0], 24'h000000);
        wr(route_pkg::OFS_ANALOG_LEVEL, 255);
        bus(1'b0, route_pkg::OFS_ANALOG_LEVEL, 32'h0, q);
        check(q[W-1:0], 24'h000080);
        // output holds until the frame boundary
        frames(1);
        held = main_output[0];
        prim[0] = 0;
        wr(route_pkg::OFS_PRIMARY, 0);
        check(main_output[0], held);
        // the next frame boundary brings the new selection: silence
        frames(1);
        check(main_output[0], '0);
        frames(2);
        check_all();
        // sweep every code, then random routings with saturation corners
        for (int it = 0; it < 12; it++) begin
            for (int n = 0; n < 8; n++) begin
                prim[n] = it < 5 ? (it * 8 + n) % 40 : $urandom_range(0, 63);
                sec[n] = it < 2 ? 0 : $urandom_range(0, 63);
                opt[n] = $urandom_range(0, 15);
            end
            fmt = 1'(it % 2);
            // the saturation corner drives its own samples, so no random set then
            if (it != 5) rand_src('1);
            if (it == 5) begin
                for (int n = 0; n < 8; n++) begin
                    dsp_a[n] <= 24'h700000;
                    dsp_b[n] <= 24'h900000;
                    prim[n] = n < 4 ? 1 + n : 9 + n;
                    sec[n] = prim[n];
                end
            end
            load_cfg();
            frames(3);
            check_all();
        end
        // second sources cleared, digital outputs trimmed by 3 dB, analog at half
        for (int n = 0; n < 8; n++) sec[n] = 0;
        alev = 64;
        dlev = 90;
        rand_src(~24'h00007F);
        load_cfg();
        frames(3);
        check_all();
        finish_test();
    end
endmodule : tb_audio_output_routing_matrix
`default_nettype wire
